// file: rtl/lsw_pkg.sv
// Shared constants and carrier types for the link switch settings bank.
// Assumes a single 20 MHz system clock and a same-clock serial engine.
package lsw_pkg;

    localparam int NREG = 5;

    // Register indices inside the bank
    localparam int IDX_MODES = 0;
    localparam int IDX_RXSET = 1;
    localparam int IDX_PULSE = 2;
    localparam int IDX_EQ = 3;
    localparam int IDX_TX = 4;

    // Register addresses, indexed as above
    localparam logic [NREG-1:0][7:0] REG_ADDR = {
        8'h20, 8'h13, 8'h11, 8'h10, 8'h00
    };
    // Reset values
    localparam logic [NREG-1:0][7:0] REG_RST = {
        8'h03, 8'h00, 8'h00, 8'h01, 8'h40
    };
    // Implemented bits; the rest read as zero
    localparam logic [NREG-1:0][7:0] REG_MASK = {
        8'h0F, 8'hFF, 8'hFF, 8'h01, 8'h41
    };

    // Field positions
    localparam int SEL_BIT = 0;
    localparam int EN_BIT = 6;
    localparam int RXON_BIT = 0;
    localparam int PE_LSB = 2;
    localparam int PTO_BIT = 1;
    localparam int OCL_BIT = 0;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_PER_MS = 20000;
    localparam int MODE_DELAY_NS = 1000;
    localparam int SET_DELAY_NS = 1000;
    localparam int DLY_W = 8;
    localparam logic [DLY_W-1:0] MODE_DELAY_CYC =
        DLY_W'((MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DLY_W-1:0] SET_DELAY_CYC =
        DLY_W'((SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [NREG-1:0][DLY_W-1:0] REG_DELAY = {
        SET_DELAY_CYC, SET_DELAY_CYC, SET_DELAY_CYC, SET_DELAY_CYC,
        MODE_DELAY_CYC
    };

    localparam int PULSE_MS = 100;
    localparam int PULSE_CYC = PULSE_MS * CLK_PER_MS;
    localparam int PULSE_W = 24;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsw_req_t;

    typedef struct packed {
        logic fast_switch_enable;
        logic fast_source_select;
        logic [3:0] a_input_term_on;
        logic [3:0] b_input_term_on;
        logic [3:0] a_input_eq_level;
        logic [3:0] b_input_eq_level;
        logic [1:0] output_emphasis_level;
        logic output_term_on;
        logic output_drive_current;
    } lsw_settings_t;

    typedef struct packed {
        logic [7:0] shadow;
        logic [7:0] applied;
        logic [DLY_W-1:0] cnt;
        logic pend;
    } lsw_reg_t;

    typedef struct packed {
        lsw_reg_t [NREG-1:0] regs;
        lsw_settings_t set;
        logic [7:0] rdata;
        logic rvalid;
    } lsw_state_t;

    typedef struct packed {
        logic [PULSE_W-1:0] cnt;
        logic active;
    } lsw_timer_t;

endpackage

// file: rtl/lsw_pulse_timer.sv
// Termination drop-out timer: holds active for a fixed number of cycles.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ns
module lsw_pulse_timer #(
    parameter int CYCLES = lsw_pkg::PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic active
);

    lsw_pkg::lsw_timer_t st_q;
    lsw_pkg::lsw_timer_t st_d;

    always_comb begin
        st_d = st_q;
        if (start) begin
            st_d.cnt = lsw_pkg::PULSE_W'(CYCLES);
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - lsw_pkg::PULSE_W'(1);
        end
        st_d.active = (st_d.cnt != '0);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign active = st_q.active;

    a_timer_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
        start |=> active && st_q.cnt == lsw_pkg::PULSE_W'(CYCLES))
        else $error("pulse timer did not load on start");

    a_timer_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.cnt == lsw_pkg::PULSE_W'(1) && !start) |=> !active)
        else $error("pulse timer did not end after its count");

endmodule

// file: rtl/lsw_settings_bank.sv
// Settings bank of a 2:1 video-link switch: source select, input
// termination and pulse, equalizer, output emphasis, termination, drive.
// Assumes a serial engine on sys_clk presents one-cycle wr/rd requests,
// wr marking the last data bit of a write.
//
// How it works
// - Input termination bit gates all inputs
// - Pulse bit drops termination about 100 ms
// - Pulse bits: A0..A3 then B3..B0
// - Equalizer bit: 6 dB low, 12 dB high
// - Two-bit field sets shared output emphasis
// - One bit turns all output terminations
// - One bit picks 10 or 20 mA
// - Defaults: source A, 6 dB, 0 dB, terminated
// - Reset low restores every default setting
// - Works unconfigured from default values alone
// - Writes in window held, latest applied later
// - Select bit picks source; change is switch
`timescale 1ns/1ns
module lsw_settings_bank #(
    parameter int PULSE_CYCLES = lsw_pkg::PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire lsw_pkg::lsw_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output lsw_pkg::lsw_settings_t settings
);

    lsw_pkg::lsw_state_t st_q;
    lsw_pkg::lsw_state_t st_d;
    logic pulse_start;
    logic pulse_active;

    function automatic logic [2:0] lsw_decode(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'(lsw_pkg::NREG);
        for (int i = 0; i < lsw_pkg::NREG; i++) begin
            if (addr == lsw_pkg::REG_ADDR[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Upper nibble runs B3..B0, so reverse it into B0..B3 order
    function automatic logic [3:0] lsw_b_order(input logic [7:0] v);
        logic [3:0] b;
        for (int k = 0; k < 4; k++) begin
            b[k] = v[7-k];
        end
        return b;
    endfunction

    function automatic lsw_pkg::lsw_state_t lsw_reset_state();
        lsw_pkg::lsw_state_t s;
        s = '0;
        for (int i = 0; i < lsw_pkg::NREG; i++) begin
            s.regs[i].shadow = lsw_pkg::REG_RST[i];
            s.regs[i].applied = lsw_pkg::REG_RST[i];
        end
        s.set.fast_switch_enable = 1'b1;
        s.set.a_input_term_on = 4'hF;
        s.set.b_input_term_on = 4'hF;
        s.set.output_term_on = 1'b1;
        s.set.output_drive_current = 1'b1;
        return s;
    endfunction

    localparam lsw_pkg::lsw_state_t RST_STATE = lsw_reset_state();

    always_comb begin
        logic [2:0] widx;
        logic [2:0] ridx;
        logic wr_i;
        logic [7:0] newv;
        logic [7:0] term;
        logic [7:0] rxset;
        logic [7:0] txset;
        widx = lsw_decode(req.addr);
        ridx = widx;
        wr_i = 1'b0;
        newv = '0;
        term = '0;
        rxset = '0;
        txset = '0;
        st_d = st_q;
        for (int i = 0; i < lsw_pkg::NREG; i++) begin
            wr_i = req.wr && (widx == 3'(i));
            newv = req.wdata & lsw_pkg::REG_MASK[i];
            if (wr_i) begin
                st_d.regs[i].shadow = newv;
            end
            if (st_q.regs[i].cnt == '0) begin
                if (wr_i) begin
                    st_d.regs[i].applied = newv;
                    st_d.regs[i].cnt = lsw_pkg::REG_DELAY[i];
                end
            end else begin
                st_d.regs[i].cnt = st_q.regs[i].cnt - lsw_pkg::DLY_W'(1);
                st_d.regs[i].pend = st_q.regs[i].pend || wr_i;
                if (st_q.regs[i].cnt == lsw_pkg::DLY_W'(1)) begin
                    st_d.regs[i].applied = st_d.regs[i].shadow;
                    st_d.regs[i].pend = 1'b0;
                end
            end
        end
        st_d.rvalid = req.rd;
        st_d.rdata = '0;
        if (req.rd && ridx < 3'(lsw_pkg::NREG)) begin
            st_d.rdata = st_q.regs[ridx].shadow;
        end
        rxset = st_d.regs[lsw_pkg::IDX_RXSET].applied;
        txset = st_d.regs[lsw_pkg::IDX_TX].applied;
        st_d.set.fast_source_select =
            st_d.regs[lsw_pkg::IDX_MODES].applied[lsw_pkg::SEL_BIT];
        st_d.set.fast_switch_enable =
            st_d.regs[lsw_pkg::IDX_MODES].applied[lsw_pkg::EN_BIT];
        term = {8{rxset[lsw_pkg::RXON_BIT]}} &
            ~({8{pulse_active}} & st_d.regs[lsw_pkg::IDX_PULSE].applied);
        st_d.set.a_input_term_on = term[3:0];
        st_d.set.b_input_term_on = lsw_b_order(term);
        st_d.set.a_input_eq_level = st_d.regs[lsw_pkg::IDX_EQ].applied[3:0];
        st_d.set.b_input_eq_level =
            lsw_b_order(st_d.regs[lsw_pkg::IDX_EQ].applied);
        st_d.set.output_emphasis_level = txset[lsw_pkg::PE_LSB +: 2];
        st_d.set.output_term_on = txset[lsw_pkg::PTO_BIT];
        st_d.set.output_drive_current = txset[lsw_pkg::OCL_BIT];
    end

    assign pulse_start =
        (st_d.set.fast_source_select != st_q.set.fast_source_select) &&
        st_d.regs[lsw_pkg::IDX_RXSET].applied[lsw_pkg::RXON_BIT];

    lsw_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(pulse_start),
        .active(pulse_active)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= RST_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign rvalid = st_q.rvalid;
    assign settings = st_q.set;

    a_rx_off_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !st_q.regs[lsw_pkg::IDX_RXSET].applied[lsw_pkg::RXON_BIT] |->
        (settings.a_input_term_on == '0 && settings.b_input_term_on == '0))
        else $error("input termination on while master bit is off");

    a_pulse_drop_b0: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (pulse_active && st_d.regs[lsw_pkg::IDX_PULSE].applied[7]) |=>
        !settings.b_input_term_on[0])
        else $error("channel B0 stayed terminated during pulse");

    a_map_order: assert property (@(posedge sys_clk) disable iff (!reset_n)
        settings.b_input_eq_level[3] ==
        st_q.regs[lsw_pkg::IDX_EQ].applied[4] &&
        settings.a_input_eq_level[0] ==
        st_q.regs[lsw_pkg::IDX_EQ].applied[0])
        else $error("equalizer bits map to wrong channels");

    a_emph_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
        settings.output_emphasis_level ==
        st_q.regs[lsw_pkg::IDX_TX].applied[lsw_pkg::PE_LSB +: 2])
        else $error("emphasis level does not follow its field");

    a_out_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
        settings.output_term_on ==
        st_q.regs[lsw_pkg::IDX_TX].applied[lsw_pkg::PTO_BIT] &&
        settings.output_drive_current ==
        st_q.regs[lsw_pkg::IDX_TX].applied[lsw_pkg::OCL_BIT])
        else $error("output termination or current wrong");

    a_reset_default: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> (!settings.fast_source_select &&
        settings.output_term_on && settings.output_emphasis_level == '0 &&
        settings.a_input_eq_level == '0 &&
        settings.a_input_term_on == 4'hF))
        else $error("settings not at defaults after reset");

    a_window_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_q.regs[lsw_pkg::IDX_TX].cnt > lsw_pkg::DLY_W'(1)) |=>
        $stable(st_q.regs[lsw_pkg::IDX_TX].applied))
        else $error("setting changed inside its delay window");

    a_window_latest: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (st_q.regs[lsw_pkg::IDX_TX].cnt == lsw_pkg::DLY_W'(1)) |=>
        st_q.regs[lsw_pkg::IDX_TX].applied ==
        st_q.regs[lsw_pkg::IDX_TX].shadow)
        else $error("window end did not apply latest write");

    a_sel_switch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $changed(settings.fast_source_select) &&
        st_q.regs[lsw_pkg::IDX_RXSET].applied[lsw_pkg::RXON_BIT] |->
        pulse_active)
        else $error("source switch did not start the pulse");

endmodule

// file: testbench/lsw_host_model.sv
// Host controller model: drives reset and one-cycle register requests.
// Assumes the settings bank samples requests on sys_clk rising edges.
`timescale 1ns/1ns
module lsw_host_model (
    input wire logic sys_clk,
    output logic reset_n,
    output lsw_pkg::lsw_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        reset_n = 1'b0;
        req = '0;
    end

    task automatic pulse_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
    endtask

    // Idle bus shows inverted values, never the stale ones
    task automatic send(input logic wr, input logic [7:0] addr,
                        input logic [7:0] data);
        @(posedge sys_clk);
        req <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic write_reg(input logic [7:0] addr,
                             input logic [7:0] data);
        send(1'b1, addr, data);
    endtask

    task automatic read_reg(input logic [7:0] addr,
                            output logic [7:0] data, output logic valid);
        send(1'b0, addr, 8'h00);
        @(negedge sys_clk);
        data = rdata;
        valid = rvalid;
    endtask
endmodule

// file: testbench/lsw_settings_bank_tb_top.sv
// Self-checking bench for the link switch settings bank.
// Assumes the host model drives reset_n and req of the bank; the bench itself drives sys_clk.
`timescale 1ns/1ns
module lsw_settings_bank_tb_top;
    localparam int PULSE_LEN = 16;
    logic sys_clk;
    logic reset_n;
    lsw_pkg::lsw_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    lsw_pkg::lsw_settings_t settings;
    logic [7:0] rst_tab [5] = '{8'h40, 8'h01, 8'h00, 8'h00, 8'h03};
    logic [7:0] adr_tab [5] = '{8'h00, 8'h10, 8'h11, 8'h13, 8'h20};
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    lsw_host_model u_host (.sys_clk(sys_clk), .reset_n(reset_n),
        .req(req), .rdata(rdata), .rvalid(rvalid));

    lsw_settings_bank #(.PULSE_CYCLES(PULSE_LEN)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .req(req),
        .rdata(rdata), .rvalid(rvalid), .settings(settings));

    // Settings packed back into register bit order
    wire logic [7:0] tx_seen = {4'h0, settings.output_emphasis_level,
        settings.output_term_on, settings.output_drive_current};
    wire logic [7:0] md_seen = {1'b0, settings.fast_switch_enable, 5'h00,
        settings.fast_source_select};
    wire logic [7:0] eq_seen = {settings.b_input_eq_level[0],
        settings.b_input_eq_level[1], settings.b_input_eq_level[2],
        settings.b_input_eq_level[3], settings.a_input_eq_level};
    wire logic [7:0] tm_seen = {settings.b_input_term_on[0],
        settings.b_input_term_on[1], settings.b_input_term_on[2],
        settings.b_input_term_on[3], settings.a_input_term_on};

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_host.read_reg(addr, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("rdata", exp, d);
    endtask

    task automatic negs(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic t_defaults();
        chk("modes", 8'h40, md_seen);
        chk("terms", 8'hFF, tm_seen);
        chk("eq", 8'h00, eq_seen);
        chk("tx", 8'h03, tx_seen);
        for (int i = 0; i < 5; i++) begin
            chk_rd(adr_tab[i], rst_tab[i]);
        end
        chk_rd(8'h05, 8'h00);
        $display("test defaults done");
    endtask

    task automatic t_tx();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {4'hA, 2'(i), ~i[0], i[1]};
            u_host.write_reg(8'h20, d);
            negs(2);
            chk("tx", d & 8'h0F, tx_seen);
            chk_rd(8'h20, d & 8'h0F);
            negs(25);
        end
        $display("test tx done");
    endtask

    task automatic t_window();
        u_host.write_reg(8'h20, 8'h0C);
        negs(3);
        chk("tx first", 8'h0C, tx_seen);
        u_host.write_reg(8'h20, 8'h07);
        negs(5);
        chk("tx held", 8'h0C, tx_seen);
        negs(14);
        chk("tx latest", 8'h07, tx_seen);
        negs(25);
        $display("test window done");
    endtask

    task automatic t_eq_rxon();
        u_host.write_reg(8'h13, 8'h1B);
        negs(2);
        chk("eq map", 8'h1B, eq_seen);
        chk_rd(8'h13, 8'h1B);
        u_host.write_reg(8'h10, 8'hFE);
        negs(2);
        chk("terms off", 8'h00, tm_seen);
        chk_rd(8'h10, 8'h00);
        negs(25);
        u_host.write_reg(8'h10, 8'h01);
        negs(2);
        chk("terms on", 8'hFF, tm_seen);
        negs(25);
        $display("test eq and termination done");
    endtask

    task automatic t_pulse();
        u_host.write_reg(8'h11, 8'h81);
        negs(25);
        u_host.write_reg(8'h00, 8'h41);
        negs(2);
        chk("source b", 8'h41, md_seen);
        negs(4);
        chk("pulse early", 8'h7E, tm_seen);
        negs(9);
        chk("pulse late", 8'h7E, tm_seen);
        negs(11);
        chk("pulse over", 8'hFF, tm_seen);
        $display("test pulse done");
    endtask

    task automatic t_reset_mid();
        u_host.write_reg(8'h20, 8'h0C);
        u_host.write_reg(8'h13, 8'hFF);
        negs(2);
        u_host.pulse_reset();
        chk("tx", 8'h03, tx_seen);
        chk("eq", 8'h00, eq_seen);
        chk("modes", 8'h40, md_seen);
        chk_rd(8'h20, 8'h03);
        $display("test reset done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("BAD timeout expected 0 seen 1");
            final_report();
        end
    end

    initial begin
        u_host.pulse_reset();
        t_defaults();
        t_tx();
        t_window();
        t_eq_rxon();
        t_pulse();
        t_reset_mid();
        final_report();
    end
endmodule
